// ===== src/lsu_pkg.sv
package lsu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned NUM_REGS = 16;

  localparam logic [REG_IDX_W-1:0] REG_SP = 4'hD;
  localparam logic [REG_IDX_W-1:0] REG_LINK = 4'hE;
  localparam logic [REG_IDX_W-1:0] REG_PC = 4'hF;

  localparam logic [DATA_W-1:0] WORD_STEP = 32'h0000_0004;
  localparam logic [DATA_W-1:0] LITERAL_MAX_BYTES = 32'h0000_03FC;
  localparam logic [DATA_W-1:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [1:0] WORD_LOW_BITS = 2'h3;
  localparam logic [3:0] LANES_WORD = 4'hF;
  localparam logic [3:0] LANES_HALF = 4'h3;
  localparam logic [3:0] LANES_BYTE = 4'h1;
  localparam logic [7:0] LOW_REG_MASK = 8'hFF;

  typedef enum logic [3:0] {
    LSU_LOAD_WORD         = 4'h0,
    LSU_LOAD_BYTE_ZERO    = 4'h1,
    LSU_LOAD_HALF_ZERO    = 4'h2,
    LSU_LOAD_BYTE_SIGN    = 4'h3,
    LSU_LOAD_HALF_SIGN    = 4'h4,
    LSU_STORE_WORD        = 4'h5,
    LSU_STORE_BYTE        = 4'h6,
    LSU_STORE_HALF        = 4'h7,
    LSU_LOAD_LITERAL      = 4'h8,
    LSU_LOAD_MULTIPLE     = 4'h9,
    LSU_STORE_MULTIPLE    = 4'hA,
    LSU_PUSH              = 4'hB,
    LSU_POP               = 4'hC
  } lsu_op_e;

  typedef enum logic [3:0] {
    LSU_ST_IDLE   = 4'b0001,
    LSU_ST_ISSUE  = 4'b0010,
    LSU_ST_WAIT   = 4'b0100,
    LSU_ST_FINISH = 4'b1000
  } lsu_state_e;

  typedef struct packed {
    lsu_op_e op;
    logic [REG_IDX_W-1:0] xferReg;
    logic [REG_IDX_W-1:0] baseReg;
    logic [NUM_REGS-1:0] regList;
    logic [DATA_W-1:0] baseVal;
    logic [DATA_W-1:0] offVal;
    logic writeback;
  } lsu_cmd_s;

  typedef struct packed {
    logic req;
    logic write;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] byteEn;
  } lsu_mem_req_s;

  typedef struct packed {
    logic we;
    logic [REG_IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } lsu_reg_wr_s;

endpackage

// ===== src/lsu_load_store_unit.sv
`timescale 1ns/1ps

// Summary of operation
// - Register-offset access address is base register plus offset register.
// - Loads write word, zero- or sign-extended byte or halfword, widened to 32 bits.
// - Stores write full word, lowest byte or lower halfword of the source.
// - None of these accesses changes the condition flags.
// - Literal load fetches a word-aligned word within 1020 bytes of the PC.
// - Multiple transfers use consecutive words from base to base plus 4(n-1).
// - Multiple transfers go in ascending register order, lowest register lowest address.
// - With writeback, base register receives base plus four times the count.
// - Push tops at SP minus four, ascending registers, SP ends at lowest.
// - Pop reads upward from SP, then SP points above the highest read.
// - Pop including PC branches to loaded value, bit 0 sets thumb bit.
module lsu_load_store_unit #(
  parameter int unsigned DATA_W = 32,
  parameter int unsigned NUM_REGS = 16
) (
  input wire logic sys_clk, // Core clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic cmdValid, // Instruction offered.
  input wire lsu_pkg::lsu_cmd_s cmd, // Decoded instruction and operands.
  output logic cmdReady, // Unit idle and accepting.
  output logic [lsu_pkg::REG_IDX_W-1:0] rfRdIdx, // Register read index.
  input wire logic [lsu_pkg::DATA_W-1:0] rfRdData, // Register read data, same cycle.
  output lsu_pkg::lsu_reg_wr_s rfWr, // Register write port.
  output lsu_pkg::lsu_mem_req_s memReq, // Memory request, held until acknowledged.
  input wire logic memAck, // Memory transfer complete.
  input wire logic [lsu_pkg::DATA_W-1:0] memRdata, // Memory read data.
  output logic branchValid, // Pulse: branch to branchTarget.
  output logic [lsu_pkg::DATA_W-1:0] branchTarget, // Branch address.
  output logic thumbBit, // Thumb state bit taken with the branch.
  output logic flagsWe, // Condition flag write enable, never set.
  output logic fault, // Pulse: alignment or range fault.
  output logic done // Pulse: instruction finished.
);

  if (DATA_W != lsu_pkg::DATA_W || NUM_REGS != lsu_pkg::NUM_REGS) begin : gParamCheck
    $error("lsu_load_store_unit supports only 32-bit data and 16 registers");
  end
  function automatic logic [lsu_pkg::REG_IDX_W-1:0] lowestIdx(input logic [NUM_REGS-1:0] m);
    lowestIdx = '0;
    for (int i = NUM_REGS - 1; i >= 0; i--) begin
      if (m[i]) begin
        lowestIdx = i[lsu_pkg::REG_IDX_W-1:0];
      end
    end
  endfunction
  function automatic logic [DATA_W-1:0] listBytes(input logic [NUM_REGS-1:0] m);
    listBytes = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (m[i]) begin
        listBytes = listBytes + lsu_pkg::WORD_STEP;
      end
    end
  endfunction
  function automatic logic isLoad(input lsu_pkg::lsu_op_e op);
    case (op)
      lsu_pkg::LSU_STORE_WORD, lsu_pkg::LSU_STORE_BYTE, lsu_pkg::LSU_STORE_HALF,
      lsu_pkg::LSU_STORE_MULTIPLE, lsu_pkg::LSU_PUSH: isLoad = 1'b0;
      default: isLoad = 1'b1;
    endcase
  endfunction
  function automatic logic [3:0] sizeLanes(input lsu_pkg::lsu_op_e op);
    case (op)
      lsu_pkg::LSU_LOAD_BYTE_ZERO, lsu_pkg::LSU_LOAD_BYTE_SIGN, lsu_pkg::LSU_STORE_BYTE: begin
        sizeLanes = lsu_pkg::LANES_BYTE;
      end
      lsu_pkg::LSU_LOAD_HALF_ZERO, lsu_pkg::LSU_LOAD_HALF_SIGN, lsu_pkg::LSU_STORE_HALF: begin
        sizeLanes = lsu_pkg::LANES_HALF;
      end
      default: sizeLanes = lsu_pkg::LANES_WORD;
    endcase
  endfunction

  lsu_pkg::lsu_state_e state_q, state_d;
  lsu_pkg::lsu_op_e op_q, op_d;
  logic [NUM_REGS-1:0] mask_q, mask_d;
  logic [DATA_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wbVal_q, wbVal_d;
  logic [lsu_pkg::REG_IDX_W-1:0] baseReg_q, baseReg_d;
  logic doWb_q, doWb_d;
  logic [lsu_pkg::REG_IDX_W-1:0] curIdx_q, curIdx_d;
  logic pcLoaded_q, pcLoaded_d;
  logic [DATA_W-1:0] pcVal_q, pcVal_d;
  logic cmdReady_q, cmdReady_d;
  lsu_pkg::lsu_reg_wr_s rfWr_q, rfWr_d;
  lsu_pkg::lsu_mem_req_s memReq_q, memReq_d;
  logic branchValid_q, branchValid_d;
  logic [DATA_W-1:0] branchTarget_q, branchTarget_d;
  logic thumbBit_q, thumbBit_d;
  logic fault_q, fault_d;
  logic done_q, done_d;
  logic flagsWe_q, flagsWe_d;
  logic [DATA_W-1:0] startAddr, startWb;
  logic [NUM_REGS-1:0] startMask, nextMask;
  logic startWbEn, misaligned;
  logic [4:0] laneShift;
  logic [DATA_W-1:0] loadShifted, loadExt;

  always_comb begin
    startAddr = cmd.baseVal + cmd.offVal;
    startMask = '0;
    startMask[cmd.xferReg] = 1'b1;
    startWb = '0;
    startWbEn = 1'b0;
    misaligned = 1'b0;
    case (cmd.op)
      lsu_pkg::LSU_LOAD_LITERAL: begin
        startAddr = (cmd.baseVal & lsu_pkg::WORD_ALIGN_MASK) + cmd.offVal;
        misaligned = (cmd.offVal[1:0] != 2'h0) || (cmd.offVal > lsu_pkg::LITERAL_MAX_BYTES);
      end
      lsu_pkg::LSU_LOAD_MULTIPLE, lsu_pkg::LSU_STORE_MULTIPLE: begin
        startAddr = cmd.baseVal;
        startMask = cmd.regList;
        startWb = cmd.baseVal + listBytes(cmd.regList);
        startWbEn = cmd.writeback;
      end
      lsu_pkg::LSU_PUSH: begin
        startAddr = cmd.baseVal - listBytes(cmd.regList);
        startMask = cmd.regList;
        startWb = startAddr;
        startWbEn = 1'b1;
      end
      lsu_pkg::LSU_POP: begin
        startAddr = cmd.baseVal;
        startMask = cmd.regList;
        startWb = cmd.baseVal + listBytes(cmd.regList);
        startWbEn = 1'b1;
      end
      default: ;
    endcase
    case (sizeLanes(cmd.op))
      lsu_pkg::LANES_HALF: misaligned = misaligned | startAddr[0];
      lsu_pkg::LANES_WORD: misaligned = misaligned | (startAddr[1:0] != 2'h0);
      default: ;
    endcase
  end
  always_comb begin
    laneShift = {addr_q[1:0], 3'h0};
    loadShifted = memRdata >> laneShift;
    case (op_q)
      lsu_pkg::LSU_LOAD_BYTE_ZERO: loadExt = {24'h00_0000, loadShifted[7:0]};
      lsu_pkg::LSU_LOAD_HALF_ZERO: loadExt = {16'h0000, loadShifted[15:0]};
      lsu_pkg::LSU_LOAD_BYTE_SIGN: loadExt = {{24{loadShifted[7]}}, loadShifted[7:0]};
      lsu_pkg::LSU_LOAD_HALF_SIGN: loadExt = {{16{loadShifted[15]}}, loadShifted[15:0]};
      default: loadExt = memRdata;
    endcase
    nextMask = mask_q;
    nextMask[curIdx_q] = 1'b0;
  end
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    mask_d = mask_q;
    addr_d = addr_q;
    wbVal_d = wbVal_q;
    baseReg_d = baseReg_q;
    doWb_d = doWb_q;
    curIdx_d = curIdx_q;
    pcLoaded_d = pcLoaded_q;
    pcVal_d = pcVal_q;
    cmdReady_d = cmdReady_q;
    rfWr_d = '0;
    memReq_d = memReq_q;
    branchValid_d = 1'b0;
    branchTarget_d = branchTarget_q;
    thumbBit_d = thumbBit_q;
    fault_d = 1'b0;
    done_d = 1'b0;
    flagsWe_d = 1'b0;
    case (state_q)
      lsu_pkg::LSU_ST_IDLE: begin
        if (cmdValid && cmdReady_q) begin
          cmdReady_d = 1'b0;
          if (misaligned) begin
            fault_d = 1'b1;
            done_d = 1'b1;
            cmdReady_d = 1'b1;
          end else begin
            op_d = cmd.op;
            mask_d = startMask;
            addr_d = startAddr;
            wbVal_d = startWb;
            baseReg_d = (cmd.op == lsu_pkg::LSU_PUSH || cmd.op == lsu_pkg::LSU_POP) ? lsu_pkg::REG_SP : cmd.baseReg;
            doWb_d = startWbEn;
            curIdx_d = lowestIdx(startMask);
            pcLoaded_d = 1'b0;
            state_d = lsu_pkg::LSU_ST_ISSUE;
          end
        end
      end
      lsu_pkg::LSU_ST_ISSUE: begin
        memReq_d = '{1'b1, ~isLoad(op_q), addr_q, rfRdData << laneShift, sizeLanes(op_q) << addr_q[1:0]};
        state_d = lsu_pkg::LSU_ST_WAIT;
      end
      lsu_pkg::LSU_ST_WAIT: begin
        if (memAck) begin
          memReq_d.req = 1'b0;
          if (isLoad(op_q)) begin
            if (curIdx_q == lsu_pkg::REG_PC) begin
              pcLoaded_d = 1'b1;
              pcVal_d = memRdata;
            end else begin
              rfWr_d = '{1'b1, curIdx_q, loadExt};
            end
          end
          mask_d = nextMask;
          addr_d = addr_q + lsu_pkg::WORD_STEP;
          curIdx_d = lowestIdx(nextMask);
          state_d = (nextMask == '0) ? lsu_pkg::LSU_ST_FINISH : lsu_pkg::LSU_ST_ISSUE;
        end
      end
      lsu_pkg::LSU_ST_FINISH: begin
        rfWr_d = '{doWb_q, baseReg_q, wbVal_q};
        if (pcLoaded_q) begin
          branchValid_d = 1'b1;
          branchTarget_d = pcVal_q;
          thumbBit_d = pcVal_q[0];
        end
        done_d = 1'b1;
        cmdReady_d = 1'b1;
        state_d = lsu_pkg::LSU_ST_IDLE;
      end
      default: begin
        cmdReady_d = 1'b1;
        memReq_d = '0;
        state_d = lsu_pkg::LSU_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= lsu_pkg::LSU_ST_IDLE;
      op_q <= lsu_pkg::LSU_LOAD_WORD;
      mask_q <= '0;
      addr_q <= '0;
      wbVal_q <= '0;
      baseReg_q <= '0;
      doWb_q <= 1'b0;
      curIdx_q <= '0;
      pcLoaded_q <= 1'b0;
      pcVal_q <= '0;
      cmdReady_q <= 1'b1;
      rfWr_q <= '0;
      memReq_q <= '0;
      branchValid_q <= 1'b0;
      branchTarget_q <= '0;
      thumbBit_q <= 1'b1;
      fault_q <= 1'b0;
      done_q <= 1'b0;
      flagsWe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      mask_q <= mask_d;
      addr_q <= addr_d;
      wbVal_q <= wbVal_d;
      baseReg_q <= baseReg_d;
      doWb_q <= doWb_d;
      curIdx_q <= curIdx_d;
      pcLoaded_q <= pcLoaded_d;
      pcVal_q <= pcVal_d;
      cmdReady_q <= cmdReady_d;
      rfWr_q <= rfWr_d;
      memReq_q <= memReq_d;
      branchValid_q <= branchValid_d;
      branchTarget_q <= branchTarget_d;
      thumbBit_q <= thumbBit_d;
      fault_q <= fault_d;
      done_q <= done_d;
      flagsWe_q <= flagsWe_d;
    end
  end

  // The register read index follows the current list member so store data is ready in ISSUE.
  assign rfRdIdx = curIdx_q;
  assign cmdReady = cmdReady_q;
  assign rfWr = rfWr_q;
  assign memReq = memReq_q;
  assign branchValid = branchValid_q;
  assign branchTarget = branchTarget_q;
  assign thumbBit = thumbBit_q;
  assign flagsWe = flagsWe_q;
  assign fault = fault_q;
  assign done = done_q;

endmodule

// ===== tb/lsu_mem_model.sv
`timescale 1ns/1ps
module lsu_mem_model (
  input wire logic sys_clk, // Core clock.
  input wire lsu_pkg::lsu_mem_req_s memReq, // Unit request.
  input wire logic slow, // Adds wait states.
  output logic memAck, // Done pulse.
  output logic [31:0] memRdata // Read data.
);
  logic [31:0] mem [256];
  logic [1:0] waitQ = 2'h0;
  initial begin
    memAck = 1'b0;
    memRdata = 32'h0;
  end
  // Read data is scrambled outside acks so stale values never look valid.
  always @(posedge sys_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq.req && !memAck) begin
      if (slow && waitQ != 2'h3) begin
        waitQ <= waitQ + 2'h1;
      end else begin
        waitQ <= 2'h0;
        memAck <= 1'b1;
        memRdata <= mem[memReq.addr[9:2]];
        for (int k = 0; k < 4; k++) begin
          if (memReq.write && memReq.byteEn[k]) begin
            mem[memReq.addr[9:2]][8*k+:8] <= memReq.wdata[8*k+:8];
          end
        end
      end
    end
  end
endmodule

// ===== tb/lsu_load_store_unit_sva.sv
`timescale 1ns/1ps
module lsu_load_store_unit_chk (
  input wire logic sys_clk, // Core clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic cmdValid, // Offered.
  input wire lsu_pkg::lsu_cmd_s cmd, // Instruction.
  input wire logic cmdReady, // Idle.
  input wire lsu_pkg::lsu_mem_req_s memReq, // Request.
  input wire logic memAck, // Ack.
  input wire logic branchValid, // Branch pulse.
  input wire logic [31:0] branchTarget, // Branch address.
  input wire logic thumbBit, // Thumb bit.
  input wire logic flagsWe, // Flag write.
  input wire logic fault, // Fault pulse.
  input wire logic done // Finish pulse.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  lsu_pkg::lsu_cmd_s cmdQ;
  logic firstQ;
  logic [31:0] lastQ;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      firstQ <= 1'b1;
    end else if (cmdValid && cmdReady) begin
      firstQ <= 1'b1;
      cmdQ <= cmd;
    end else if (memAck) begin
      firstQ <= 1'b0;
      lastQ <= memReq.addr;
    end
  end
  addr_sum_a: assert property ($rose(memReq.req) && firstQ && cmdQ.op <= lsu_pkg::LSU_STORE_HALF
    |-> memReq.addr == cmdQ.baseVal + cmdQ.offVal) else $error("offset address wrong");
  half_lanes_a: assert property (memReq.req && cmdQ.op == lsu_pkg::LSU_STORE_HALF
    |-> memReq.byteEn == (lsu_pkg::LANES_HALF << memReq.addr[1:0])) else $error("half lanes wrong");
  flags_quiet_a: assert property (flagsWe == 1'b0) else $error("flags written");
  literal_addr_a: assert property ($rose(memReq.req) && firstQ && cmdQ.op == lsu_pkg::LSU_LOAD_LITERAL
    |-> !memReq.write && memReq.addr == (cmdQ.baseVal & lsu_pkg::WORD_ALIGN_MASK) + cmdQ.offVal)
    else $error("literal address wrong");
  word_step_a: assert property ($rose(memReq.req) && !firstQ && cmdQ.op >= lsu_pkg::LSU_LOAD_MULTIPLE
    |-> memReq.addr == lastQ + lsu_pkg::WORD_STEP) else $error("step not four");
  push_base_a: assert property ($rose(memReq.req) && firstQ && cmdQ.op == lsu_pkg::LSU_PUSH
    |-> memReq.addr == cmdQ.baseVal - 32'($countones(cmdQ.regList)) * lsu_pkg::WORD_STEP)
    else $error("push start wrong");
  pop_base_a: assert property ($rose(memReq.req) && firstQ && cmdQ.op == lsu_pkg::LSU_POP
    |-> memReq.addr == cmdQ.baseVal) else $error("pop start wrong");
  branch_thumb_a: assert property (branchValid |-> done ##1 thumbBit == $past(branchTarget[0]))
    else $error("branch thumb wrong");
  fault_skip_a: assert property (fault |-> done && !memReq.req) else $error("fault with access");
endmodule
bind lsu_load_store_unit lsu_load_store_unit_chk u_chk (.sys_clk, .rst_b, .cmdValid, .cmd, .cmdReady,
  .memReq, .memAck, .branchValid, .branchTarget, .thumbBit, .flagsWe, .fault, .done);

// ===== tb/lsu_load_store_unit_tb.sv
`timescale 1ns/1ps
module lsu_load_store_unit_tb;
  logic sys_clk = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, slow = 1'b0;
  logic cmdReady, memAck, branchValid, thumbBit, flagsWe, fault, done;
  lsu_pkg::lsu_cmd_s cmd = '0;
  lsu_pkg::lsu_mem_req_s memReq;
  lsu_pkg::lsu_reg_wr_s rfWr;
  logic [3:0] rfRdIdx;
  logic [31:0] rfRdData, memRdata, branchTarget, w;
  logic [31:0] regs [16];
  logic [35:0] expQ [$];
  int bad_count = 0, total_checks = 0, seed = 32'h1ad5;
  always #2 sys_clk = ~sys_clk;
  assign rfRdData = regs[rfRdIdx];
  lsu_load_store_unit u_dut (.sys_clk, .rst_b, .cmdValid, .cmd, .cmdReady, .rfRdIdx, .rfRdData, .rfWr,
    .memReq, .memAck, .memRdata, .branchValid, .branchTarget, .thumbBit, .flagsWe, .fault, .done);
  lsu_mem_model u_mem (.sys_clk, .memReq, .slow, .memAck, .memRdata);
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(logic [35:0] seen, logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic e(logic [3:0] i, logic [31:0] d);
    expQ.push_back({i, d});
  endtask
  task automatic run(logic [3:0] o, logic [3:0] x, logic [15:0] l, logic [31:0] bv, ov, logic wb, ef);
    int i;
    cmd <= '{lsu_pkg::lsu_op_e'(o), x, x, l, bv, ov, wb};
    cmdValid <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge sys_clk);
    if (i == 100) begin
      bad_count++;
      results();
    end else begin
      check({35'h0, fault}, {35'h0, ef});
      check({35'h0, flagsWe}, 36'h0);
    end
  endtask
  // Register writes and branches are matched against notes in issue order.
  always @(posedge sys_clk) begin
    if (rfWr.we === 1'b1) check({rfWr.idx, rfWr.data}, expQ.pop_front());
    if (branchValid === 1'b1) check({4'hF, branchTarget}, expQ.pop_front());
    if (branchValid === 1'b1) check({35'h0, thumbBit}, {35'h0, regs[14][0]});
  end
  initial begin
    for (int k = 0; k < 16; k++) regs[k] = $random(seed);
    regs[2] = regs[2] | 32'h8080_8080;
    regs[14][0] = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      run(4'h5, 4'h2, '0, 32'h40, 32'h10, 1'b0, 1'b0);
      run(4'h6, 4'h3, '0, 32'h50, 32'h1, 1'b0, 1'b0);
      run(4'h5, 4'h5, '0, 32'h30, 32'h28, 1'b0, 1'b0);
      run(4'h7, 4'h4, '0, 32'h5A, '0, 1'b0, 1'b0);
      w = {regs[2][31:16], regs[3][7:0], regs[2][7:0]};
      e(4'h1, w);
      run(4'h0, 4'h1, '0, 32'h20, 32'h30, 1'b0, 1'b0);
      e(4'h1, {24'h0, w[31:24]});
      run(4'h1, 4'h1, '0, 32'h53, '0, 1'b0, 1'b0);
      e(4'h1, {{24{w[31]}}, w[31:24]});
      run(4'h3, 4'h1, '0, 32'h53, '0, 1'b0, 1'b0);
      e(4'h1, {16'h0, w[31:16]});
      run(4'h2, 4'h1, '0, 32'h52, '0, 1'b0, 1'b0);
      e(4'h1, {{16{w[31]}}, w[31:16]});
      run(4'h4, 4'h1, '0, 32'h52, '0, 1'b0, 1'b0);
      e(4'h1, {24'h0, regs[3][7:0]});
      run(4'h1, 4'h1, '0, 32'h51, '0, 1'b0, 1'b0);
      e(4'h1, {regs[4][15:0], regs[5][15:0]});
      run(4'h0, 4'h1, '0, 32'h58, '0, 1'b0, 1'b0);
      run(4'h0, 4'h1, '0, 32'h52, '0, 1'b0, 1'b1);
      run(4'h7, 4'h4, '0, 32'h51, '0, 1'b0, 1'b1);
      run(4'h8, 4'h1, '0, 32'h2, 32'h3FE, 1'b0, 1'b1);
      run(4'h8, 4'h1, '0, 32'h2, 32'h400, 1'b0, 1'b1);
      run(4'h5, 4'h6, '0, 32'h3FC, '0, 1'b0, 1'b0);
      e(4'h1, regs[6]);
      run(4'h8, 4'h1, '0, 32'h2, 32'h3FC, 1'b0, 1'b0);
      e(4'h1, w);
      run(4'h8, 4'h1, '0, 32'h3, 32'h50, 1'b0, 1'b0);
      run(4'hA, 4'h0, 16'h0001, 32'h82, '0, 1'b1, 1'b1);
      e(4'h0, 32'h8C);
      run(4'hA, 4'h0, 16'h001A, 32'h80, '0, 1'b1, 1'b0);
      e(4'h5, regs[1]);
      e(4'h6, regs[3]);
      e(4'h7, regs[4]);
      e(4'h0, 32'h8C);
      run(4'h9, 4'h0, 16'h00E0, 32'h80, '0, 1'b1, 1'b0);
      e(4'h1, regs[1]);
      e(4'h2, regs[3]);
      run(4'h9, 4'h2, 16'h0006, 32'h80, '0, 1'b0, 1'b0);
      e(4'h1, 32'h98);
      run(4'hA, 4'h1, 16'h0006, 32'h90, '0, 1'b1, 1'b0);
      e(4'h3, regs[2]);
      e(4'h0, 32'h98);
      run(4'h9, 4'h0, 16'h0008, 32'h94, '0, 1'b1, 1'b0);
      e(4'hD, 32'hB4);
      run(4'hB, 4'h0, 16'h4005, 32'hC0, '0, 1'b0, 1'b0);
      e(4'h1, regs[0]);
      e(4'h3, regs[2]);
      e(4'hD, 32'hC0);
      e(4'hF, regs[14]);
      run(4'hC, 4'h0, 16'h800A, 32'hB4, '0, 1'b0, 1'b0);
      $display("test pass %0d finished", p);
    end
    repeat (4) @(posedge sys_clk);
    check(36'(expQ.size()), 36'h0);
    results();
  end
endmodule
